// File: hdl/pmpp_fifo.sv
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: depth is a power of two
// Notes: full and empty come from a fill counter
module pmpp_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;

   assign in_ready = (cnt_r != AW'(0) + (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rp_r];

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= wp_r + AW'(1);
         end
         if (pop) begin
            rp_r <= rp_r + AW'(1);
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : pmpp_fifo

// File: hdl/pmpp_packer.sv
// Purpose: assembles host bus words into 18-bit pixels for display memory
// Assumes: host strobe is synchronous; every cycle it is high while host_ready is high takes one word
// Notes: pixels leave through a 4-word fifo; a full fifo stalls the host
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
module pmpp_packer #(
   parameter int FIFO_DEPTH = pmpp_pkg::PMPP_FIFO_DEPTH
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // host pins
   input wire logic [3:0] interface_select_pins,
   input wire pmpp_pkg::pmpp_host_t host_bus,
   output logic host_ready,
   // pixel stream
   output logic pix_valid,
   input wire logic pix_ready,
   output pmpp_pkg::pmpp_pixel_t pix_data,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   import pmpp_pkg::*;

   typedef enum logic [2:0] {
      PMPP_PH0 = 3'b001,
      PMPP_PH1 = 3'b010,
      PMPP_PH2 = 3'b100
   } pmpp_phase_t;

   pmpp_phase_t phase_r;
   logic [2:0] host_pixel_format_field;
   logic [1:0] wide_pixel_packing_field;
   logic [7:0] last_cmd_r;
   logic [7:0] pix_count_r;
   logic [17:0] hold_r;
   logic ack_r;
   logic [31:0] rdata_r;
   logic [15:0] w16;
   logic [7:0] cmd_byte;
   logic [8:0] w9;
   logic word_in;
   logic cmd_in;
   logic data_in;
   logic emit;
   pmpp_pixel_t pix_nxt;
   pmpp_phase_t phase_nxt;
   logic fifo_in_ready;
   logic is16_mode;
   logic is2_mode;

   assign is2_mode = (interface_select_pins == PMPP_IF_16_II);
   assign is16_mode = (interface_select_pins == PMPP_IF_16_I) || is2_mode;
   // second variant skips D9 and shifts the low half up by one line
   assign w16 = is2_mode ? {host_bus.data[17:10], host_bus.data[8:1]} : host_bus.data[15:0];
   // the 9-bit bus carries its command byte on the top lines
   assign cmd_byte = is2_mode ? host_bus.data[8:1] :
      (interface_select_pins == PMPP_IF_9_II) ? host_bus.data[17:10] : host_bus.data[7:0];
   assign w9 = host_bus.data[17:9];
   assign host_ready = fifo_in_ready;
   assign word_in = host_bus.wr && host_ready;
   assign cmd_in = word_in && !host_bus.dc;
   assign data_in = word_in && host_bus.dc;

   always_comb begin
      emit = 1'b0;
      pix_nxt = '0;
      phase_nxt = phase_r;
      if (data_in) begin
         if (interface_select_pins == PMPP_IF_9_II) begin
            if (wide_pixel_packing_field == PMPP_PACK_01) begin
               case (phase_r)
                  PMPP_PH0: phase_nxt = PMPP_PH1;
                  PMPP_PH1: phase_nxt = PMPP_PH2;
                  default: begin
                     emit = 1'b1;
                     phase_nxt = PMPP_PH0;
                  end
               endcase
               pix_nxt = {hold_r[11:0], host_bus.data[16:11]};
            end else begin
               if (phase_r == PMPP_PH0) begin
                  phase_nxt = PMPP_PH1;
               end else begin
                  emit = 1'b1;
                  phase_nxt = PMPP_PH0;
               end
               pix_nxt = {hold_r[8:0], w9};
            end
         end else if (host_pixel_format_field == PMPP_FMT_16 || !is16_mode) begin
            emit = 1'b1;
            // five-bit components widened by repeating their msb
            pix_nxt = {w16[15:11], w16[15], w16[10:5], w16[4:0], w16[4]};
         end else begin
            case (wide_pixel_packing_field)
               PMPP_PACK_00: begin
                  case (phase_r)
                     PMPP_PH0: phase_nxt = PMPP_PH1;
                     PMPP_PH1: begin
                        emit = 1'b1;
                        phase_nxt = PMPP_PH2;
                        // six-bit fields sit at the top of each byte half
                        pix_nxt = {hold_r[15:10], hold_r[7:2], w16[15:10]};
                     end
                     default: begin
                        emit = 1'b1;
                        phase_nxt = PMPP_PH0;
                        pix_nxt = {hold_r[7:2], w16[15:10], w16[7:2]};
                     end
                  endcase
               end
               PMPP_PACK_01: begin
                  if (phase_r == PMPP_PH0) begin
                     phase_nxt = PMPP_PH1;
                  end else begin
                     emit = 1'b1;
                     phase_nxt = PMPP_PH0;
                     pix_nxt = {hold_r[15:10], hold_r[7:2], w16[15:10]};
                  end
               end
               PMPP_PACK_10: begin
                  if (phase_r == PMPP_PH0) begin
                     phase_nxt = PMPP_PH1;
                  end else begin
                     emit = 1'b1;
                     phase_nxt = PMPP_PH0;
                     pix_nxt = {hold_r[15:0], w16[15:14]};
                  end
               end
               default: begin
                  if (phase_r == PMPP_PH0) begin
                     phase_nxt = PMPP_PH1;
                  end else begin
                     emit = 1'b1;
                     phase_nxt = PMPP_PH0;
                     pix_nxt = {hold_r[1:0], w16};
                  end
               end
            endcase
         end
      end
      if (cmd_in) begin
         phase_nxt = PMPP_PH0;
      end
   end

   // phase survives between data words until a command arrives
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         phase_r <= PMPP_PH0;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         hold_r <= '0;
      end else if (data_in) begin
         if (interface_select_pins == PMPP_IF_9_II && wide_pixel_packing_field == PMPP_PACK_01) begin
            hold_r <= {hold_r[11:0], host_bus.data[16:11]};
         end else if (interface_select_pins == PMPP_IF_9_II) begin
            hold_r <= {9'h000, w9};
         end else begin
            hold_r <= {2'h0, w16};
         end
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         last_cmd_r <= '0;
         pix_count_r <= '0;
      end else begin
         if (cmd_in) begin
            last_cmd_r <= cmd_byte;
            pix_count_r <= '0;
         end else if (emit) begin
            // ascending pixel index within a line, wraps after the last
            pix_count_r <= (pix_count_r == PMPP_LINE_LAST) ? 8'h00 : pix_count_r + 8'h01;
         end
      end
   end

   pmpp_fifo #(
      .WIDTH(18),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .in_valid(emit),
      .in_ready(fifo_in_ready),
      .in_data(pix_nxt),
      .out_valid(pix_valid),
      .out_ready(pix_ready),
      .out_data(pix_data)
   );

   // avalon slave: one wait cycle, answer on the second edge
   assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
   assign avs_readdata = rdata_r;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ack_r <= 1'b0;
         rdata_r <= '0;
         host_pixel_format_field <= PMPP_RST_FMT;
         wide_pixel_packing_field <= PMPP_RST_PACK;
      end else begin
         ack_r <= (avs_read || avs_write) && !ack_r;
         // write lands on the edge that completes the transfer
         if (avs_write && ack_r && avs_address == PMPP_REG_CTRL) begin
            host_pixel_format_field <= avs_writedata[PMPP_CTRL_FMT_LSB +: 3];
            wide_pixel_packing_field <= avs_writedata[PMPP_CTRL_PACK_LSB +: 2];
         end
         if (avs_read && !ack_r) begin
            case (avs_address)
               PMPP_REG_CTRL: rdata_r <= {26'h0, wide_pixel_packing_field, 1'b0, host_pixel_format_field};
               PMPP_REG_STAT: rdata_r <= {23'h0, pix_valid, host_ready, phase_r, interface_select_pins};
               PMPP_REG_CMD: rdata_r <= {24'h0, last_cmd_r};
               PMPP_REG_CNT: rdata_r <= {24'h0, pix_count_r};
               default: rdata_r <= '0;
            endcase
         end
      end
   end

   // 18-bit bus select is not decoded; it takes the one-word 65k path on D15..D0

   a_cmd_phase_reset: assert property (@(posedge ref_clk) disable iff (!resetn)
      cmd_in |=> phase_r == PMPP_PH0) else $error("phase not reset by command");
   a_one_word_pixel: assert property (@(posedge ref_clk) disable iff (!resetn)
      data_in && is16_mode && host_pixel_format_field == PMPP_FMT_16 |-> emit) else $error("65k word lost");
   a_red_field_map: assert property (@(posedge ref_clk) disable iff (!resetn)
      emit && is16_mode && !is2_mode && host_pixel_format_field == PMPP_FMT_16
      |-> pix_nxt.red[5:1] == host_bus.data[15:11]) else $error("red field misplaced");
   a_mode01_two: assert property (@(posedge ref_clk) disable iff (!resetn)
      data_in && is16_mode && host_pixel_format_field == PMPP_FMT_18 && wide_pixel_packing_field == PMPP_PACK_01
      && phase_r == PMPP_PH0 |-> !emit) else $error("mode 01 emitted early");
   a_mode10_blue: assert property (@(posedge ref_clk) disable iff (!resetn)
      emit && is16_mode && host_pixel_format_field == PMPP_FMT_18 && wide_pixel_packing_field == PMPP_PACK_10
      |-> pix_nxt.blue[1:0] == w16[15:14]) else $error("mode 10 blue wrong");
   a_mode11_tail: assert property (@(posedge ref_clk) disable iff (!resetn)
      emit && is16_mode && host_pixel_format_field == PMPP_FMT_18 && wide_pixel_packing_field == PMPP_PACK_11
      |-> pix_nxt[15:0] == w16) else $error("mode 11 tail wrong");
   a_cmd_line_map: assert property (@(posedge ref_clk) disable iff (!resetn)
      cmd_in && is2_mode |=> last_cmd_r == $past(host_bus.data[8:1])) else $error("variant two cmd lines");
   a_mode00_third: assert property (@(posedge ref_clk) disable iff (!resetn)
      data_in && is16_mode && host_pixel_format_field == PMPP_FMT_18 && wide_pixel_packing_field == PMPP_PACK_00
      && phase_r == PMPP_PH2 |-> emit ##1 phase_r == PMPP_PH0) else $error("mode 00 cycle broken");
   a_nine_pair: assert property (@(posedge ref_clk) disable iff (!resetn)
      data_in && interface_select_pins == PMPP_IF_9_II && wide_pixel_packing_field == PMPP_PACK_00
      && phase_r == PMPP_PH1 |-> emit) else $error("9-bit pair lost");
   a_nine_triplet: assert property (@(posedge ref_clk) disable iff (!resetn)
      data_in && interface_select_pins == PMPP_IF_9_II && wide_pixel_packing_field == PMPP_PACK_01
      && phase_r != PMPP_PH2 |-> !emit) else $error("9-bit triplet early");
endmodule : pmpp_packer

// File: hdl/pmpp_pkg.sv
// Purpose: constants and carrier types of the parallel host pixel packer
// Assumes: one clock, host strobe already synchronous
// Notes: pixel output carries 6-6-6 components; 65k pixels are widened
// Function
// - Interface-select value 0001 selects the first-variant 16-bit bus and its pixel formats.
// - Interface-select value 1001 selects the second-variant 16-bit bus on D17..D10 and D8..D1, skipping D9.
// - Interface-select value 0011 selects the first-variant 18-bit bus; the packer does not decode it and takes the one-word 65k path.
// - Pixel format 101 on the 16-bit bus makes every data word one whole pixel.
// - In the one-word 16-bit format red comes from D15..D11, green from D10..D5, blue from D4..D0.
// - Pixel format 110 on the 16-bit bus uses two-bit packing mode to arrange 18-bit pixels over words.
// - Packing mode 00 builds two pixels from three words: R0/G0, B0/R1, G1/B1 as high/low bytes.
// - Packing mode 01 takes red high and green low from word one, blue high from word two.
// - Packing mode 10 takes R, G and B5..2 from word one and B1..0 from the top of word two.
// - Packing mode 11 takes R5..4 from the bottom of word one and R3..0, G and B from word two.
// - A command byte comes with the select low on the low data lines; pixel words come with it high.
// - The second-variant 16-bit bus reads commands from D8..D1 and pixel fields from D17..D10, D8..D1.
// - Second-variant 9-bit bus, mode 00: two words, R5..0 G5..3 then G2..0 B5..0.
// - Second-variant 9-bit bus, mode 01: one six-bit component per word on D16..D11, R then G then B.
// - The 16-bit bus supports both 65k and 262k color depth by pixel format.
// - Pixels stream in ascending order and packing phase is kept across a data run.
package pmpp_pkg;
   localparam logic [3:0] PMPP_IF_16_I = 4'h1;
   localparam logic [3:0] PMPP_IF_18_I = 4'h3;
   localparam logic [3:0] PMPP_IF_9_II = 4'hA;
   localparam logic [3:0] PMPP_IF_16_II = 4'h9;
   localparam logic [2:0] PMPP_FMT_16 = 3'h5;
   localparam logic [2:0] PMPP_FMT_18 = 3'h6;
   localparam logic [1:0] PMPP_PACK_00 = 2'h0;
   localparam logic [1:0] PMPP_PACK_01 = 2'h1;
   localparam logic [1:0] PMPP_PACK_10 = 2'h2;
   localparam logic [1:0] PMPP_PACK_11 = 2'h3;
   // register byte addresses on the avalon slave
   localparam logic [3:0] PMPP_REG_CTRL = 4'h0;
   localparam logic [3:0] PMPP_REG_STAT = 4'h4;
   localparam logic [3:0] PMPP_REG_CMD = 4'h8;
   localparam logic [3:0] PMPP_REG_CNT = 4'hC;
   localparam int PMPP_CTRL_FMT_LSB = 0;
   localparam int PMPP_CTRL_PACK_LSB = 4;
   localparam logic [2:0] PMPP_RST_FMT = 3'h5;
   localparam logic [1:0] PMPP_RST_PACK = 2'h0;
   localparam logic [7:0] PMPP_LINE_LAST = 8'hEF;
   localparam int PMPP_FIFO_DEPTH = 4;

   typedef struct packed {
      logic [5:0] red;
      logic [5:0] green;
      logic [5:0] blue;
   } pmpp_pixel_t;

   typedef struct packed {
      logic wr;
      logic dc;
      logic [17:0] data;
   } pmpp_host_t;
endpackage : pmpp_pkg

// File: verif/parallel_mcu_pixel_packer_tb.sv
// Purpose: self-checking bench of the host pixel packer
// Assumes: one clock, register access over the avalon slave
// Notes: unused data lines carry ones so stray bits show up
module parallel_mcu_pixel_packer_tb import pmpp_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] sel = PMPP_IF_16_I;
   logic pix_ready = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, rd;
   logic host_ready, pix_valid, avs_waitrequest;
   pmpp_host_t host_bus;
   pmpp_pixel_t pix_data;
   pmpp_pixel_t got[$], exq[$];
   logic [18:0] wq[$];
   // {select, format, packing}
   logic [8:0] cfg[13] = '{9'h034, 9'h134, 9'h074, 9'h038, 9'h039, 9'h03A, 9'h03B,
      9'h138, 9'h139, 9'h13A, 9'h13B, 9'h158, 9'h159};
   int errors = 0;
   int tests_run = 0;

   pmpp_packer dut_u (.ref_clk, .resetn, .interface_select_pins(sel), .host_bus, .host_ready,
      .pix_valid, .pix_ready, .pix_data, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest);
   pmpp_host_model host_u (.ref_clk, .host_ready, .host_bus);

   always #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (resetn === 1'b1 && pix_valid === 1'b1 && pix_ready === 1'b1) got.push_back(pix_data);

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      tests_run++;
      if (seen !== want) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check

   task automatic end_of_test();
      $display("tests_run=%0d errors=%0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   task automatic av_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask : av_wr

   task automatic av_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
   endtask : av_rd

   function automatic logic [18:0] cw(input logic [3:0] s, input logic [7:0] c);
      if (s == PMPP_IF_16_II) return {10'h1FF, c, 1'b1};
      if (s == PMPP_IF_9_II) return {1'b0, c, 10'h3FF};
      return {11'h3FF, c};
   endfunction : cw

   function automatic logic [18:0] dw(input logic [3:0] s, input logic [15:0] w);
      if (s == PMPP_IF_16_II) return {1'b1, w[15:8], 1'b1, w[7:0], 1'b1};
      return {3'h7, w};
   endfunction : dw

   // queues the bus words of two pixels and the pixels expected back
   task automatic pair(input logic [3:0] s, input logic [2:0] f, input logic [1:0] m,
         input pmpp_pixel_t a, input pmpp_pixel_t b);
      pmpp_pixel_t p;
      pmpp_pixel_t q[2];
      q = '{a, b};
      if (f == PMPP_FMT_18 && s != PMPP_IF_9_II && m == PMPP_PACK_00) begin
         wq.push_back(dw(s, {a.red, 2'h3, a.green, 2'h3}));
         wq.push_back(dw(s, {a.blue, 2'h3, b.red, 2'h3}));
         wq.push_back(dw(s, {b.green, 2'h3, b.blue, 2'h3}));
      end
      foreach (q[i]) begin
         p = q[i];
         if (f == PMPP_FMT_16) begin
            wq.push_back(dw(s, {p.red[5:1], p.green, p.blue[5:1]}));
            p = '{{p.red[5:1], p.red[5]}, p.green, {p.blue[5:1], p.blue[5]}};
         end else if (s == PMPP_IF_9_II && m == PMPP_PACK_00) begin
            wq.push_back({1'b1, p.red, p.green[5:3], 9'h1FF});
            wq.push_back({1'b1, p.green[2:0], p.blue, 9'h1FF});
         end else if (s == PMPP_IF_9_II) begin
            wq.push_back({2'h3, p.red, 11'h7FF});
            wq.push_back({2'h3, p.green, 11'h7FF});
            wq.push_back({2'h3, p.blue, 11'h7FF});
         end else if (m == PMPP_PACK_01) begin
            wq.push_back(dw(s, {p.red, 2'h3, p.green, 2'h3}));
            wq.push_back(dw(s, {p.blue, 10'h3FF}));
         end else if (m == PMPP_PACK_10) begin
            wq.push_back(dw(s, {p.red, p.green, p.blue[5:2]}));
            wq.push_back(dw(s, {p.blue[1:0], 14'h3FFF}));
         end else if (m == PMPP_PACK_11) begin
            wq.push_back(dw(s, {14'h3FFF, p.red[5:4]}));
            wq.push_back(dw(s, {p.red[3:0], p.green, p.blue}));
         end
         exq.push_back(p);
      end
   endtask : pair

   task automatic run_check(input logic [31:0] cnt);
      int n;
      n = 0;
      host_u.burst(wq);
      while (got.size() < exq.size() && n < 500) begin
         @(posedge ref_clk);
         n++;
      end
      check(32'(got.size()), 32'(exq.size()));
      foreach (exq[i]) check({14'h0, got[i]}, {14'h0, exq[i]});
      got.delete();
      exq.delete();
      av_rd(PMPP_REG_CMD, rd);
      check(rd, 32'h2C);
      av_rd(PMPP_REG_CNT, rd);
      check(rd, cnt);
   endtask : run_check

   initial begin
      repeat (6) @(posedge ref_clk);
      resetn <= 1'b1;
      av_rd(PMPP_REG_CTRL, rd);
      check(rd, {26'h0, PMPP_RST_PACK, 1'b0, PMPP_RST_FMT});
      av_wr(PMPP_REG_STAT, 32'hFFFFFFFF);
      av_rd(4'h2, rd);
      check(rd, 32'h0);
      av_rd(PMPP_REG_CTRL, rd);
      check(rd, 32'h5);
      $display("test registers done");
      foreach (cfg[k]) begin
         sel <= cfg[k][8:5];
         av_wr(PMPP_REG_CTRL, {26'h0, cfg[k][1:0], 1'b0, cfg[k][4:2]});
         wq = {cw(cfg[k][8:5], 8'h2C)};
         pair(cfg[k][8:5], cfg[k][4:2], cfg[k][1:0], '{6'h2A, 6'h15, 6'h33}, '{6'h0C, 6'h27, 6'h31});
         run_check(2);
         av_rd(PMPP_REG_STAT, rd);
         check(rd, {23'h0, 2'b01, 3'h1, cfg[k][8:5]});
         $display("test config %h done", cfg[k]);
      end
      // half a pixel then a command: the stray word must vanish
      sel <= PMPP_IF_16_I;
      av_wr(PMPP_REG_CTRL, 32'h16);
      wq = {cw(PMPP_IF_16_I, 8'h2C), dw(PMPP_IF_16_I, 16'h5A5A), cw(PMPP_IF_16_I, 8'h2C)};
      pair(PMPP_IF_16_I, PMPP_FMT_18, PMPP_PACK_01, '{6'h01, 6'h3E, 6'h12}, '{6'h2D, 6'h00, 6'h3C});
      run_check(2);
      $display("test phase restart done");
      av_wr(PMPP_REG_CTRL, 32'h5);
      wq = {cw(PMPP_IF_16_I, 8'h2C)};
      for (int i = 0; i < 121; i++) pair(PMPP_IF_16_I, PMPP_FMT_16, PMPP_PACK_00,
         '{i[5:0], i[6:1], ~i[5:0]}, '{i[7:2], ~i[5:0], i[5:0]});
      run_check(2);
      $display("test line wrap done");
      // sink stalls: four pixels fill the buffer, the fifth waits
      pix_ready <= 1'b0;
      wq = {cw(PMPP_IF_16_I, 8'h2C)};
      pair(PMPP_IF_16_I, PMPP_FMT_16, PMPP_PACK_00, '{6'h3F, 6'h01, 6'h20}, '{6'h11, 6'h22, 6'h33});
      pair(PMPP_IF_16_I, PMPP_FMT_16, PMPP_PACK_00, '{6'h05, 6'h0A, 6'h14}, '{6'h28, 6'h30, 6'h0F});
      host_u.burst(wq);
      @(negedge ref_clk);
      check({30'h0, host_ready, pix_valid}, 32'h1);
      wq = {};
      pair(PMPP_IF_16_I, PMPP_FMT_16, PMPP_PACK_00, '{6'h07, 6'h38, 6'h19}, '{6'h26, 6'h0B, 6'h3D});
      fork
         run_check(6);
         begin
            repeat (5) @(posedge ref_clk);
            pix_ready <= 1'b1;
         end
      join
      $display("test buffer full done");
      end_of_test();
   end

   // roughly fifty times the expected length of the run
   initial begin
      #1200000;
      errors++;
      end_of_test();
   end
endmodule : parallel_mcu_pixel_packer_tb

// File: verif/pmpp_host_model.sv
// Purpose: host processor model driving the parallel pixel bus
// Assumes: burst is entered right after a rising clock edge
// Notes: released data lines show the inverse of the last word
module pmpp_host_model import pmpp_pkg::*; (
   // clock
   input wire logic ref_clk,
   // host pins
   input wire logic host_ready,
   output pmpp_pkg::pmpp_host_t host_bus
);
   initial begin
      host_bus = '{wr: 1'b0, dc: 1'b1, data: 18'h00000};
   end

   // entries are {select, lines}; strobe stays up across a burst
   task automatic burst(input logic [18:0] w[$]);
      @(posedge ref_clk);
      foreach (w[i]) begin
         host_bus <= '{wr: 1'b1, dc: w[i][18], data: w[i][17:0]};
         // a refused word is dropped by the device, so keep offering it
         do @(posedge ref_clk); while (host_ready !== 1'b1);
      end
      host_bus <= '{wr: 1'b0, dc: 1'b1, data: ~w[w.size()-1][17:0]};
   endtask : burst
endmodule : pmpp_host_model
